// >>> design/ccd_pkg.sv
// Shared constants and types for the clear, call and decrement execution block.
package ccd_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_TOS = 8'h10;
    localparam logic [7:0] OFF_WDT = 8'h14;
    localparam logic [7:0] OFF_PRE = 8'h18;
    localparam logic [7:0] OFF_CFG = 8'h1c;
    localparam logic [7:0] OFF_FADDR = 8'h20;
    localparam logic [7:0] OFF_FDATA = 8'h24;
    localparam logic [7:0] OFF_BUSY = 8'h28;

    // ------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_PG_LO = 5;
    localparam int ST_PG_HI = 6;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] STATUS_SW_MASK = 8'he7;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam int CFG_PSA = 0;
    localparam logic CFG_PSA_RST = 1'b0;

    // ------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------
    localparam int OP_LSB = 8;
    localparam int OP_MSB = 11;
    localparam int DEST_BIT = 5;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_CLR_ACC = 4'h1;
    localparam logic [3:0] OP_KICK = 4'h2;
    localparam logic [3:0] OP_CLR_REG = 4'h3;
    localparam logic [3:0] OP_COMP = 4'h4;
    localparam logic [3:0] OP_DEC = 4'h5;
    localparam logic [3:0] OP_DEC_SKIP = 4'h6;
    localparam logic [3:0] OP_CALL = 4'h8;
    localparam int NUM_FREGS = 32;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ALU_COMP, ALU_DEC} ccd_alu_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CALL_WAIT, ST_SKIP_NOP} ccd_state_t;

endpackage

// >>> design/ccd_alu_if.sv
// Carrier between the execution core and its file-register arithmetic unit.
`timescale 1ns/1ps
interface ccd_alu_if;
    ccd_pkg::ccd_alu_op_t op;
    logic [7:0] operand;
    logic [7:0] result;
    logic zero;
    modport alu (input op, input operand, output result, output zero);
    modport core (output op, output operand, input result, input zero);
endinterface

// >>> design/ccd_alu.sv
// Arithmetic unit for complement and decrement of a file register.
`timescale 1ns/1ps
module ccd_alu (
    ccd_alu_if.alu alu
);
    always_comb
    begin
        case (alu.op)
            ccd_pkg::ALU_COMP: alu.result = ~alu.operand;
            ccd_pkg::ALU_DEC: alu.result = alu.operand - 8'h01;
            default: alu.result = alu.operand;
        endcase
    end

    assign alu.zero = (alu.result == 8'h00);
endmodule

// >>> design/ccd_exec.sv
// Execution core for clear, call, watchdog kick and decrement instructions.
`timescale 1ns/1ps
// Function
// - Clearing the accumulator loads zero into it and sets the zero flag.
// - A call first pushes the program counter plus one onto the return stack top.
// - A call loads its 8-bit target into program counter bits 7 to 0.
// - A call copies status bits 6:5 to counter bits 10:9 and clears counter bit 8.
// - A call takes two cycles and leaves the status flags alone.
// - Kicking the watchdog resets its counter to zero.
// - Kicking the watchdog also zeroes the prescaler when it is assigned to the watchdog.
// - Kicking the watchdog sets the expired and sleep flags and changes no other status bit.
// - Clearing a file register writes zero to it and sets the zero flag.
// - Complement inverts a file register into the accumulator or back, updating zero.
// - Decrement subtracts one into the accumulator or back, updating zero.
// - Decrement and skip stores the result by destination and changes no status flag.
// - A zero decrement and skip result discards the next instruction, taking two cycles.
module ccd_exec (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ccd_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [ccd_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [ccd_pkg::DATA_W-1:0] bus_rdata,
    output logic busy
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] status;
        logic [10:0] pc;
        logic [10:0] tos;
        logic [7:0] wdt;
        logic [7:0] pre;
        logic psa;
        logic [4:0] faddr;
        logic [ccd_pkg::NUM_FREGS-1:0][7:0] fregs;
        ccd_pkg::ccd_state_t st;
        logic [ccd_pkg::DATA_W-1:0] rdata;
    } ccd_core_t;

    localparam ccd_core_t CORE_RST = '{
        acc: 8'h00,
        status: ccd_pkg::STATUS_RST,
        pc: ccd_pkg::PC_RST,
        tos: ccd_pkg::PC_RST,
        wdt: 8'h00,
        pre: 8'h00,
        psa: ccd_pkg::CFG_PSA_RST,
        faddr: 5'h00,
        fregs: '0,
        st: ccd_pkg::ST_IDLE,
        rdata: '0
    };

    logic [1:0] rst_sync_r;
    logic rst_sync_n;
    ccd_core_t s_r;
    ccd_core_t s_nxt;
    ccd_alu_if alu_bus ();
    logic exec;
    logic [3:0] op;
    logic [4:0] fidx;
    logic dest_reg;
    logic [7:0] kval;
    logic wdt_tick;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_sync_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Instruction fields and arithmetic unit
    // ------------------------------------------------------------
    assign op = bus_wdata[ccd_pkg::OP_MSB:ccd_pkg::OP_LSB];
    assign fidx = bus_wdata[4:0];
    assign dest_reg = bus_wdata[ccd_pkg::DEST_BIT];
    assign kval = bus_wdata[7:0];
    assign exec = bus_wr && (bus_addr == ccd_pkg::OFF_INSTR) && (s_r.st == ccd_pkg::ST_IDLE);
    assign alu_bus.op = (op == ccd_pkg::OP_COMP) ? ccd_pkg::ALU_COMP : ccd_pkg::ALU_DEC;
    assign alu_bus.operand = s_r.fregs[fidx];

    ccd_alu u_alu (
        .alu(alu_bus)
    );

    assign wdt_tick = s_r.psa ? (s_r.pre == 8'hff) : 1'b1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        s_nxt.pre = s_r.pre + 8'h01;
        if (wdt_tick)
        begin
            s_nxt.wdt = s_r.wdt + 8'h01;
            if (s_r.wdt == 8'hff)
                s_nxt.status[ccd_pkg::ST_TO] = 1'b0;
        end
        case (s_r.st)
            ccd_pkg::ST_IDLE:
            begin
                if (exec)
                begin
                    s_nxt.pc = s_r.pc + 11'h001;
                    case (op)
                        ccd_pkg::OP_CLR_ACC:
                        begin
                            s_nxt.acc = 8'h00;
                            s_nxt.status[ccd_pkg::ST_Z] = 1'b1;
                        end
                        ccd_pkg::OP_KICK:
                        begin
                            s_nxt.wdt = 8'h00;
                            if (s_r.psa)
                                s_nxt.pre = 8'h00;
                            s_nxt.status[ccd_pkg::ST_TO] = 1'b1;
                            s_nxt.status[ccd_pkg::ST_PD] = 1'b1;
                        end
                        ccd_pkg::OP_CLR_REG:
                        begin
                            s_nxt.fregs[fidx] = 8'h00;
                            s_nxt.status[ccd_pkg::ST_Z] = 1'b1;
                        end
                        ccd_pkg::OP_COMP, ccd_pkg::OP_DEC:
                        begin
                            if (dest_reg)
                                s_nxt.fregs[fidx] = alu_bus.result;
                            else
                                s_nxt.acc = alu_bus.result;
                            s_nxt.status[ccd_pkg::ST_Z] = alu_bus.zero;
                        end
                        ccd_pkg::OP_DEC_SKIP:
                        begin
                            if (dest_reg)
                                s_nxt.fregs[fidx] = alu_bus.result;
                            else
                                s_nxt.acc = alu_bus.result;
                            if (alu_bus.zero)
                                s_nxt.st = ccd_pkg::ST_SKIP_NOP;
                        end
                        ccd_pkg::OP_CALL:
                        begin
                            s_nxt.tos = s_r.pc + 11'h001;
                            s_nxt.pc = {s_r.status[ccd_pkg::ST_PG_HI:ccd_pkg::ST_PG_LO],
                                        1'b0, kval};
                            s_nxt.st = ccd_pkg::ST_CALL_WAIT;
                        end
                        default:
                        begin
                            s_nxt.pc = s_r.pc + 11'h001;
                        end
                    endcase
                end
                else if (bus_wr)
                begin
                    case (bus_addr)
                        ccd_pkg::OFF_ACC: s_nxt.acc = bus_wdata[7:0];
                        ccd_pkg::OFF_STATUS:
                            s_nxt.status = (s_nxt.status & ~ccd_pkg::STATUS_SW_MASK)
                                | (bus_wdata[7:0] & ccd_pkg::STATUS_SW_MASK);
                        ccd_pkg::OFF_PC: s_nxt.pc = bus_wdata[10:0];
                        ccd_pkg::OFF_CFG: s_nxt.psa = bus_wdata[ccd_pkg::CFG_PSA];
                        ccd_pkg::OFF_FADDR: s_nxt.faddr = bus_wdata[4:0];
                        ccd_pkg::OFF_FDATA: s_nxt.fregs[s_r.faddr] = bus_wdata[7:0];
                        default: s_nxt.acc = s_r.acc;
                    endcase
                end
            end
            ccd_pkg::ST_CALL_WAIT:
            begin
                s_nxt.st = ccd_pkg::ST_IDLE;
            end
            ccd_pkg::ST_SKIP_NOP:
            begin
                s_nxt.pc = s_r.pc + 11'h001;
                s_nxt.st = ccd_pkg::ST_IDLE;
            end
            default:
            begin
                s_nxt.st = ccd_pkg::ST_IDLE;
            end
        endcase
        if (bus_rd)
        begin
            case (bus_addr)
                ccd_pkg::OFF_ACC: s_nxt.rdata = {24'h000000, s_r.acc};
                ccd_pkg::OFF_STATUS: s_nxt.rdata = {24'h000000, s_r.status};
                ccd_pkg::OFF_PC: s_nxt.rdata = {21'h0, s_r.pc};
                ccd_pkg::OFF_TOS: s_nxt.rdata = {21'h0, s_r.tos};
                ccd_pkg::OFF_WDT: s_nxt.rdata = {24'h000000, s_r.wdt};
                ccd_pkg::OFF_PRE: s_nxt.rdata = {24'h000000, s_r.pre};
                ccd_pkg::OFF_CFG: s_nxt.rdata = {31'h0, s_r.psa};
                ccd_pkg::OFF_FADDR: s_nxt.rdata = {27'h0, s_r.faddr};
                ccd_pkg::OFF_FDATA: s_nxt.rdata = {24'h000000, s_r.fregs[s_r.faddr]};
                ccd_pkg::OFF_BUSY:
                    s_nxt.rdata = {31'h0, s_r.st != ccd_pkg::ST_IDLE};
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            s_r <= CORE_RST;
        else
            s_r <= s_nxt;
    end

    assign bus_rdata = s_r.rdata;
    assign busy = (s_r.st != ccd_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_two_cycle;
        busy ##1 !busy;
    endsequence

    property p_clear_acc;
        exec && op == ccd_pkg::OP_CLR_ACC |=> s_r.acc == 8'h00 && s_r.status[ccd_pkg::ST_Z];
    endproperty
    a_clear_acc: assert property (p_clear_acc) else $error("accumulator clear failed");

    property p_call_push;
        exec && op == ccd_pkg::OP_CALL |=> s_r.tos == $past(s_r.pc) + 11'h001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address wrong");

    property p_call_low;
        exec && op == ccd_pkg::OP_CALL |=> s_r.pc[7:0] == $past(kval) ##1 $stable(s_r.pc);
    endproperty
    a_call_low: assert property (p_call_low) else $error("call target wrong");

    property p_call_high;
        exec && op == ccd_pkg::OP_CALL
            |=> s_r.pc[10:9] == $past(s_r.status[6:5]) && !s_r.pc[8];
    endproperty
    a_call_high: assert property (p_call_high) else $error("call page bits wrong");

    property p_call_two;
        exec && op == ccd_pkg::OP_CALL |=> s_two_cycle;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call length wrong");

    property p_kick_wdt;
        exec && op == ccd_pkg::OP_KICK |=> s_r.wdt == 8'h00;
    endproperty
    a_kick_wdt: assert property (p_kick_wdt) else $error("watchdog not reset");

    property p_kick_pre;
        exec && op == ccd_pkg::OP_KICK && s_r.psa |=> s_r.pre == 8'h00;
    endproperty
    a_kick_pre: assert property (p_kick_pre) else $error("prescaler not reset");

    property p_kick_flags;
        exec && op == ccd_pkg::OP_KICK
            |=> s_r.status[4:3] == 2'b11 && s_r.status[7:5] == $past(s_r.status[7:5])
                && s_r.status[2:0] == $past(s_r.status[2:0]);
    endproperty
    a_kick_flags: assert property (p_kick_flags) else $error("kick status wrong");

    property p_clear_reg;
        exec && op == ccd_pkg::OP_CLR_REG
            |=> s_r.fregs[$past(fidx)] == 8'h00 && s_r.status[ccd_pkg::ST_Z];
    endproperty
    a_clear_reg: assert property (p_clear_reg) else $error("register clear failed");

    property p_comp;
        exec && op == ccd_pkg::OP_COMP && dest_reg
            |=> s_r.fregs[$past(fidx)] == ~$past(alu_bus.operand);
    endproperty
    a_comp: assert property (p_comp) else $error("complement wrong");

    property p_dec;
        exec && op == ccd_pkg::OP_DEC && !dest_reg
            |=> s_r.acc == $past(alu_bus.operand) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");

    property p_skip_flags;
        exec && op == ccd_pkg::OP_DEC_SKIP
            |=> s_r.status[2:0] == $past(s_r.status[2:0]);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");

    property p_skip_nop;
        exec && op == ccd_pkg::OP_DEC_SKIP && alu_bus.operand == 8'h01
            |=> s_two_cycle ##0 s_r.pc == $past(s_r.pc, 2) + 11'h002;
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skip not taken");

    property p_zero_flag;
        exec && (op == ccd_pkg::OP_COMP || op == ccd_pkg::OP_DEC)
            |=> s_r.status[ccd_pkg::ST_Z] == ($past(alu_bus.result) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

endmodule

// >>> verification/tb.sv
// Self-checking testbench for the clear, call and decrement execution core.
`timescale 1ns/1ps
module tb;
    logic sys_clk;
    logic rst_n;
    logic [ccd_pkg::ADDR_W-1:0] bus_addr;
    logic [ccd_pkg::DATA_W-1:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [ccd_pkg::DATA_W-1:0] bus_rdata;
    logic busy;
    int error_cnt;
    int total_checks;

    ccd_exec dut_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .busy(busy)
    );

    // ------------------------------------------------------------
    // Clock, bus tasks and comparison
    // ------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic exec(input logic [31:0] w, output logic bz);
        wr(ccd_pkg::OFF_INSTR, w);
        #1;
        bz = busy;
        if (bz === 1'b1)
            @(posedge sys_clk);
    endtask

    task automatic set_f(input logic [4:0] f, input logic [7:0] v);
        wr(ccd_pkg::OFF_FADDR, {27'h0, f});
        wr(ccd_pkg::OFF_FDATA, {24'h0, v});
    endtask

    function automatic logic [31:0] iw(logic [3:0] op, logic dst, logic [4:0] f);
        return {20'h0, op, 2'b00, dst, f};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_clear;
        logic [31:0] d;
        logic bz;
        wr(ccd_pkg::OFF_ACC, 32'h5a);
        wr(ccd_pkg::OFF_STATUS, 32'h00);
        exec(iw(ccd_pkg::OP_CLR_ACC, 1'b0, 5'h00), bz);
        rd(ccd_pkg::OFF_ACC, d);
        chk(d, 32'h0, "acc after clear");
        rd(ccd_pkg::OFF_STATUS, d);
        chk({31'h0, d[ccd_pkg::ST_Z]}, 32'h1, "zero after clear acc");
        set_f(5'h1f, 8'ha5);
        wr(ccd_pkg::OFF_STATUS, 32'h00);
        exec(iw(ccd_pkg::OP_CLR_REG, 1'b0, 5'h1f), bz);
        rd(ccd_pkg::OFF_FDATA, d);
        chk(d, 32'h0, "file reg after clear");
        rd(ccd_pkg::OFF_STATUS, d);
        chk({31'h0, d[ccd_pkg::ST_Z]}, 32'h1, "zero after clear reg");
        rd(8'h40, d);
        chk(d, 32'h0, "unmapped read");
        rd(ccd_pkg::OFF_BUSY, d);
        chk(d, 32'h0, "busy register idle");
        $display("test_clear done");
    endtask

    task automatic test_call;
        logic [31:0] s0;
        logic [31:0] d;
        wr(ccd_pkg::OFF_ACC, 32'h11);
        wr(ccd_pkg::OFF_STATUS, 32'h44);
        wr(ccd_pkg::OFF_PC, 32'h1ff);
        rd(ccd_pkg::OFF_STATUS, s0);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= ccd_pkg::OFF_INSTR;
        bus_wdata <= 32'h8a7;
        @(posedge sys_clk);
        bus_addr <= ccd_pkg::OFF_ACC;
        bus_wdata <= 32'h77;
        #1;
        chk({31'h0, busy}, 32'h1, "busy in second call cycle");
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        #1;
        chk({31'h0, busy}, 32'h0, "busy after call");
        rd(ccd_pkg::OFF_ACC, d);
        chk(d, 32'h11, "write during busy dropped");
        @(posedge sys_clk);
        #1;
        chk(bus_rdata, 32'h0, "read data after its cycle");
        rd(ccd_pkg::OFF_PC, d);
        chk(d, {21'h0, s0[6:5], 1'b0, 8'ha7}, "pc after call");
        rd(ccd_pkg::OFF_TOS, d);
        chk(d, 32'h200, "return address");
        rd(ccd_pkg::OFF_STATUS, d);
        chk(d, s0, "status after call");
        $display("test_call done");
    endtask

    task automatic test_alu;
        logic [7:0] vals[4];
        logic [7:0] v;
        logic [7:0] r;
        logic [3:0] op;
        logic [4:0] f;
        logic [31:0] d;
        logic bz;
        vals = '{8'hff, 8'h0f, 8'h01, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            v = vals[i >> 1];
            op = (i < 4) ? ccd_pkg::OP_COMP : ccd_pkg::OP_DEC;
            r = (i < 4) ? ~v : v - 8'h01;
            f = 5'(i + 3);
            set_f(f, v);
            wr(ccd_pkg::OFF_ACC, 32'h33);
            wr(ccd_pkg::OFF_STATUS, (r == 8'h00) ? 32'h00 : 32'h04);
            exec(iw(op, i[0], f), bz);
            rd(ccd_pkg::OFF_ACC, d);
            chk(d, {24'h0, i[0] ? 8'h33 : r}, "acc after alu op");
            rd(ccd_pkg::OFF_FDATA, d);
            chk(d, {24'h0, i[0] ? r : v}, "file reg after alu op");
            rd(ccd_pkg::OFF_STATUS, d);
            chk({31'h0, d[ccd_pkg::ST_Z]}, {31'h0, r == 8'h00}, "zero flag");
        end
        $display("test_alu done");
    endtask

    task automatic test_skip;
        logic [31:0] s0;
        logic [31:0] d;
        logic bz;
        for (int i = 0; i < 2; i++)
        begin
            set_f(5'h02, (i == 0) ? 8'h01 : 8'h05);
            wr(ccd_pkg::OFF_ACC, 32'h33);
            wr(ccd_pkg::OFF_STATUS, (i == 0) ? 32'h00 : 32'h04);
            wr(ccd_pkg::OFF_PC, 32'h020);
            rd(ccd_pkg::OFF_STATUS, s0);
            exec(iw(ccd_pkg::OP_DEC_SKIP, i == 0, 5'h02), bz);
            chk({31'h0, bz}, {31'h0, i == 0}, "busy on skip");
            rd(ccd_pkg::OFF_PC, d);
            chk(d, (i == 0) ? 32'h022 : 32'h021, "pc after skip");
            rd(ccd_pkg::OFF_STATUS, d);
            chk(d, s0, "status after skip");
            rd((i == 0) ? ccd_pkg::OFF_FDATA : ccd_pkg::OFF_ACC, d);
            chk(d, (i == 0) ? 32'h00 : 32'h04, "skip result");
        end
        $display("test_skip done");
    endtask

    task automatic test_kick;
        logic [31:0] s0;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        logic bz;
        wr(ccd_pkg::OFF_CFG, 32'h0);
        wr(ccd_pkg::OFF_STATUS, 32'h64);
        repeat (300) @(posedge sys_clk);
        rd(ccd_pkg::OFF_STATUS, s0);
        chk({31'h0, s0[ccd_pkg::ST_TO]}, 32'h0, "expired after wrap");
        exec(iw(ccd_pkg::OP_KICK, 1'b0, 5'h00), bz);
        rd(ccd_pkg::OFF_STATUS, d);
        chk(d, s0 | 32'h18, "status after kick");
        rd(ccd_pkg::OFF_WDT, d);
        chk({31'h0, d < 32'h8}, 32'h1, "count after kick");
        rd(ccd_pkg::OFF_PRE, a);
        exec(iw(ccd_pkg::OP_KICK, 1'b0, 5'h00), bz);
        rd(ccd_pkg::OFF_PRE, b);
        rd(ccd_pkg::OFF_PRE, c);
        exec(iw(ccd_pkg::OP_NOP, 1'b0, 5'h00), bz);
        rd(ccd_pkg::OFF_PRE, d);
        chk({24'h0, b[7:0] - a[7:0]}, {24'h0, d[7:0] - c[7:0]}, "prescaler kept");
        wr(ccd_pkg::OFF_CFG, 32'h1);
        repeat (20) @(posedge sys_clk);
        exec(iw(ccd_pkg::OP_KICK, 1'b0, 5'h00), bz);
        rd(ccd_pkg::OFF_PRE, d);
        chk({31'h0, d < 32'h8}, 32'h1, "prescaler cleared");
        rd(ccd_pkg::OFF_WDT, d);
        chk(d, 32'h0, "count after kick with prescaler");
        $display("test_kick done");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("MISMATCH at %0t: run timed out", $time);
        tally_and_finish();
    end

    initial
    begin
        error_cnt = 0;
        total_checks = 0;
        rst_n = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_clear();
        test_call();
        test_alu();
        test_skip();
        test_kick();
        tally_and_finish();
    end
endmodule
